// ### pkg/sync_pkg.sv
// Purpose: shared constants for the sync/restart link
// Assumes: both ends run on the converter sampling clock
// Notes: device register offsets match the converter map
package sync_pkg;
    localparam int NUM_CH = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int EXT_W = 4;
    // device registers
    localparam logic [7:0] DEV_CTRL_ADDR = 8'h01;
    localparam logic [7:0] DEV_STATUS_ADDR = 8'h02;
    localparam logic [7:0] DEV_EXT_ADDR = 8'h06;
    localparam int RM_POS = 0;
    localparam int DECIM_EN_POS = 1;
    localparam int DECIM_LSB = 2;
    localparam int DECIM_W = 4;
    localparam logic [15:0] DEV_CTRL_RST = 16'h0000;
    localparam logic [15:0] DEV_EXT_RST = 16'h0000;
    // restart timing in input clock cycles
    localparam int FIXED_RESTART_CYC = 2;
    localparam int MIN_SYNC_WIDTH_CYC = 2;
    // controller registers
    localparam logic [7:0] CTL_CMD_ADDR = 8'h00;
    localparam logic [7:0] CTL_WIDTH_ADDR = 8'h01;
    localparam logic [7:0] CTL_STATUS_ADDR = 8'h02;
    localparam int CTL_REMOTE_POS = 4;
    localparam int CMD_GO_POS = 0;
    localparam int CMD_AUTO_POS = 1;
    localparam logic [15:0] CTL_CMD_RST = 16'h0000;
    localparam logic [7:0] CTL_WIDTH_RST = 8'h04;
endpackage : sync_pkg

// ### pkg/sync_link_if.sv
// Purpose: wires between sync controller and converter
// Assumes: single clock, register port is same-clock
// Notes: differential pairs carried as two plain wires
`timescale 1ns/1ps
interface sync_link_if;
    logic sync_in_pos;
    logic sync_in_neg;
    logic [sync_pkg::NUM_CH-1:0] data_ready_pos;
    logic [sync_pkg::NUM_CH-1:0] data_ready_neg;
    logic [sync_pkg::ADDR_W-1:0] reg_addr;
    logic [sync_pkg::DATA_W-1:0] reg_wdata;
    logic [sync_pkg::DATA_W-1:0] reg_rdata;
    logic reg_wr;
    logic reg_rd;
    modport device(input sync_in_pos, input sync_in_neg, input reg_addr, input reg_wdata,
        input reg_wr, input reg_rd, output data_ready_pos, output data_ready_neg,
        output reg_rdata);
    modport controller(output sync_in_pos, output sync_in_neg, output reg_addr,
        output reg_wdata, output reg_wr, output reg_rd, input data_ready_pos,
        input data_ready_neg, input reg_rdata);
endinterface : sync_link_if

// ### verilog/sync_2ff.sv
// Purpose: two-flop level synchroniser
// Assumes: input may change at any time
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module sync_2ff #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : sync_2ff

// ### verilog/adc_sync_restart_device.sv
// Purpose: converter-side sync and data-ready restart logic
// Assumes: CLK is the sampling clock; link register port same-clock
// Notes: data-ready toggles once per cycle as a clock enable image
// Function
// - controller holds sync high minimum width
// - sync stretched by programmable 0..15 cycles
// - run select low freezes clocks during sync
// - run select high keeps toggling, realign on fall
// - controller pulses sync after key mode changes
// - other setting changes need no sync
// - leaving test mode needs no sync
// - decimation dividers reset while sync active
// - pipeline restarts first edge after release
// - data-ready resumes fixed 2 cycles later
// - extra delay equals low 4 bits of extension register
// - controller avoids sync edges in forbidden window
// - each channel has own data-ready pair
// - sync is differential, aligns data-ready clocks
`timescale 1ns/1ps
module adc_sync_restart_device #(
    parameter int NUM_CH = sync_pkg::NUM_CH
) (
    input wire logic CLK,
    input wire logic RST_N,
    sync_link_if.device LINK,
    output logic PIPE_RUN,
    output logic DECIM_TICK,
    output logic DATA_VALID,
    output logic SYNC_ACTIVE
);
    typedef enum logic [1:0] {ST_RUN, ST_HELD, ST_DELAY} dev_state_e;

    logic [1:0] sync_pair;
    logic sync_lvl;
    logic rm;
    logic decim_en;
    logic [sync_pkg::DECIM_W-1:0] decim_ratio;

    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic [15:0] ext_r;
    logic [15:0] ext_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    dev_state_e state_r;
    dev_state_e state_nxt;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic phase_r;
    logic phase_nxt;
    logic [sync_pkg::DECIM_W-1:0] decim_r;
    logic [sync_pkg::DECIM_W-1:0] decim_nxt;
    logic tick_nxt;
    logic run_nxt;
    logic valid_nxt;
    logic [NUM_CH-1:0] drp_r;
    logic [NUM_CH-1:0] drn_r;

    // pos and neg pass the flops separately; decode after the second stage
    sync_2ff #(.W(2)) u_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .d({LINK.sync_in_pos, LINK.sync_in_neg}),
        .q(sync_pair)
    );

    assign sync_lvl = sync_pair[1] & ~sync_pair[0];
    assign rm = ctrl_r[sync_pkg::RM_POS];
    assign decim_en = ctrl_r[sync_pkg::DECIM_EN_POS];
    assign decim_ratio = ctrl_r[sync_pkg::DECIM_LSB +: sync_pkg::DECIM_W];

    // register port: write takes effect next edge, read data one cycle later
    always_comb begin
        ctrl_nxt = ctrl_r;
        ext_nxt = ext_r;
        rdata_nxt = 16'h0000;
        if (LINK.reg_wr) begin
            if (LINK.reg_addr == sync_pkg::DEV_CTRL_ADDR) begin
                ctrl_nxt = LINK.reg_wdata;
            end else if (LINK.reg_addr == sync_pkg::DEV_EXT_ADDR) begin
                ext_nxt = LINK.reg_wdata;
            end
        end
        if (LINK.reg_rd) begin
            if (LINK.reg_addr == sync_pkg::DEV_CTRL_ADDR) begin
                rdata_nxt = ctrl_r;
            end else if (LINK.reg_addr == sync_pkg::DEV_EXT_ADDR) begin
                rdata_nxt = ext_r;
            end else if (LINK.reg_addr == sync_pkg::DEV_STATUS_ADDR) begin
                rdata_nxt = {13'h0000, state_r == ST_DELAY, state_r == ST_HELD, sync_lvl};
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_r <= sync_pkg::DEV_CTRL_RST;
            ext_r <= sync_pkg::DEV_EXT_RST;
            rdata_r <= 16'h0000;
        end else begin
            ctrl_r <= ctrl_nxt;
            ext_r <= ext_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign LINK.reg_rdata = rdata_r;

    // restart sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        phase_nxt = phase_r;
        unique case (state_r)
            ST_RUN: begin
                phase_nxt = ~phase_r;
                if (sync_lvl) begin
                    state_nxt = ST_HELD;
                    if (!rm) begin
                        phase_nxt = phase_r;
                    end
                end
            end
            ST_HELD: begin
                // run select high avoids starving the far-end pll
                phase_nxt = rm ? ~phase_r : phase_r;
                if (!sync_lvl) begin
                    state_nxt = ST_DELAY;
                    phase_nxt = 1'b0;
                    // fixed part plus stretch, loaded on release
                    cnt_nxt = 5'(sync_pkg::FIXED_RESTART_CYC) + {1'b0, ext_r[3:0]};
                end
            end
            ST_DELAY: begin
                phase_nxt = 1'b0;
                if (sync_lvl) begin
                    state_nxt = ST_HELD;
                end else if (cnt_r == 5'd1) begin
                    state_nxt = ST_RUN;
                    phase_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 5'd1;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= ST_RUN;
            cnt_r <= 5'd0;
            phase_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            phase_r <= phase_nxt;
        end
    end

    // decimation divider and status outputs
    always_comb begin
        decim_nxt = decim_r;
        tick_nxt = 1'b0;
        run_nxt = (state_nxt != ST_HELD) || rm;
        if (decim_en && sync_lvl) begin
            decim_nxt = '0;
        end else if (decim_en && run_nxt) begin
            if (decim_r == decim_ratio) begin
                decim_nxt = '0;
                tick_nxt = 1'b1;
            end else begin
                decim_nxt = decim_r + 1'b1;
            end
        end
        // outputs are stale while dividers sit in reset
        valid_nxt = run_nxt && (state_nxt == ST_RUN) && !(decim_en && sync_lvl);
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            decim_r <= '0;
            DECIM_TICK <= 1'b0;
            PIPE_RUN <= 1'b1;
            DATA_VALID <= 1'b0;
            SYNC_ACTIVE <= 1'b0;
        end else begin
            decim_r <= decim_nxt;
            DECIM_TICK <= tick_nxt;
            PIPE_RUN <= run_nxt;
            DATA_VALID <= valid_nxt;
            SYNC_ACTIVE <= sync_lvl;
        end
    end

    // one data-ready pair per channel, all aligned by the same sequencer
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_drdy
        always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
                drp_r[ch] <= 1'b0;
                drn_r[ch] <= 1'b1;
            end else begin
                drp_r[ch] <= phase_nxt;
                drn_r[ch] <= ~phase_nxt;
            end
        end
    end

    assign LINK.data_ready_pos = drp_r;
    assign LINK.data_ready_neg = drn_r;
endmodule : adc_sync_restart_device

// ### verilog/adc_sync_restart_controller.sv
// Purpose: controller end: issues sync pulses, measures restart
// Assumes: software port is same-clock; data-ready arrives from pins
// Notes: addresses with the remote bit set reach the converter map
`timescale 1ns/1ps
module adc_sync_restart_controller (
    input wire logic CLK,
    input wire logic RST_N,
    sync_link_if.controller LINK,
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    output logic BUSY
);
    typedef enum logic [1:0] {CS_IDLE, CS_ASSERT, CS_MEAS} ctl_state_e;

    logic remote;
    logic [1:0] drdy_s;
    logic drdy_d_r;
    logic go;
    logic [7:0] width_eff;
    logic [15:0] cmd_r;
    logic [15:0] cmd_nxt;
    logic [7:0] width_r;
    logic [7:0] width_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic rsel_r;
    ctl_state_e state_r;
    ctl_state_e state_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] lat_r;
    logic [7:0] lat_nxt;
    logic sync_r;
    logic sync_nxt;

    assign remote = ADDR[sync_pkg::CTL_REMOTE_POS];
    assign LINK.reg_addr = {4'h0, ADDR[3:0]};
    assign LINK.reg_wdata = WDATA;
    assign LINK.reg_wr = WR && remote;
    assign LINK.reg_rd = RD && remote;

    // data-ready comes off pins: two flops before use
    sync_2ff #(.W(2)) u_drdy (
        .clk(CLK),
        .rst_n(RST_N),
        .d({LINK.data_ready_pos[0], LINK.data_ready_neg[0]}),
        .q(drdy_s)
    );

    // never go below the documented minimum pulse
    assign width_eff = (width_r < 8'(sync_pkg::MIN_SYNC_WIDTH_CYC)) ?
        8'(sync_pkg::MIN_SYNC_WIDTH_CYC) : width_r;
    assign go = (WR && !remote && ADDR == sync_pkg::CTL_CMD_ADDR && WDATA[sync_pkg::CMD_GO_POS])
        || (LINK.reg_wr && cmd_r[sync_pkg::CMD_AUTO_POS]
        && LINK.reg_addr == sync_pkg::DEV_CTRL_ADDR);

    always_comb begin
        cmd_nxt = cmd_r;
        width_nxt = width_r;
        rdata_nxt = 16'h0000;
        if (WR && !remote) begin
            if (ADDR == sync_pkg::CTL_CMD_ADDR) begin
                cmd_nxt = WDATA & ~(16'h0001 << sync_pkg::CMD_GO_POS);
            end else if (ADDR == sync_pkg::CTL_WIDTH_ADDR) begin
                width_nxt = WDATA[7:0];
            end
        end
        if (RD && !remote) begin
            if (ADDR == sync_pkg::CTL_CMD_ADDR) begin
                rdata_nxt = cmd_r;
            end else if (ADDR == sync_pkg::CTL_WIDTH_ADDR) begin
                rdata_nxt = {8'h00, width_r};
            end else if (ADDR == sync_pkg::CTL_STATUS_ADDR) begin
                rdata_nxt = {6'h00, state_r == CS_MEAS, state_r == CS_ASSERT, lat_r};
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cmd_r <= sync_pkg::CTL_CMD_RST;
            width_r <= sync_pkg::CTL_WIDTH_RST;
            rdata_r <= 16'h0000;
            rsel_r <= 1'b0;
        end else begin
            cmd_r <= cmd_nxt;
            width_r <= width_nxt;
            rdata_r <= rdata_nxt;
            rsel_r <= RD && remote;
        end
    end

    assign RDATA = rsel_r ? LINK.reg_rdata : rdata_r;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        lat_nxt = lat_r;
        sync_nxt = sync_r;
        unique case (state_r)
            CS_IDLE: begin
                if (go) begin
                    state_nxt = CS_ASSERT;
                    sync_nxt = 1'b1;
                    cnt_nxt = width_eff;
                end
            end
            CS_ASSERT: begin
                if (cnt_r == 8'd1) begin
                    state_nxt = CS_MEAS;
                    sync_nxt = 1'b0;
                    cnt_nxt = 8'd0;
                end else begin
                    cnt_nxt = cnt_r - 8'd1;
                end
            end
            CS_MEAS: begin
                if (drdy_s[1] && !drdy_s[0] && !drdy_d_r) begin
                    state_nxt = CS_IDLE;
                    lat_nxt = cnt_r;
                end else if (cnt_r == 8'hFF) begin
                    state_nxt = CS_IDLE;
                    lat_nxt = cnt_r;
                end else begin
                    cnt_nxt = cnt_r + 8'd1;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= CS_IDLE;
            cnt_r <= 8'd0;
            lat_r <= 8'd0;
            sync_r <= 1'b0;
            drdy_d_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            lat_r <= lat_nxt;
            sync_r <= sync_nxt;
            drdy_d_r <= drdy_s[1] && !drdy_s[0];
        end
    end

    // sync edges only right after CLK edges keep clear of the forbidden window
    assign LINK.sync_in_pos = sync_r;
    assign LINK.sync_in_neg = ~sync_r;
    assign BUSY = state_r != CS_IDLE;
endmodule : adc_sync_restart_controller

// ### test/adc_sync_restart_assertions.sv
// Purpose: checker on the sync link between controller and converter
// Assumes: one clock; device registers mirrored from link writes
// Notes: restart window allows for synchroniser slack
`timescale 1ns/1ps
module adc_sync_restart_assertions (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic sync_in_pos,
    input wire logic sync_in_neg,
    input wire logic [sync_pkg::NUM_CH-1:0] data_ready_pos,
    input wire logic [sync_pkg::NUM_CH-1:0] data_ready_neg,
    input wire logic [sync_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [sync_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [sync_pkg::DATA_W-1:0] reg_rdata,
    input wire logic reg_wr,
    input wire logic reg_rd
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic run_sel_r;
    logic [15:0] ext_r;
    logic [7:0] cnt_r;
    logic arm_r;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            run_sel_r <= 1'b0;
            ext_r <= 16'h0000;
            cnt_r <= 8'h00;
            arm_r <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == sync_pkg::DEV_CTRL_ADDR) begin
                run_sel_r <= reg_wdata[sync_pkg::RM_POS];
            end
            if (reg_wr && reg_addr == sync_pkg::DEV_EXT_ADDR) begin
                ext_r <= reg_wdata;
            end
            if (sync_in_pos) begin
                arm_r <= 1'b1;
                cnt_r <= 8'h00;
            end else if (arm_r) begin
                cnt_r <= cnt_r + 8'h01;
                // only the first rise after release is measured
                if ($rose(data_ready_pos[0])) begin
                    arm_r <= 1'b0;
                end
            end
        end
    end
    sequence sync_held_s;
        sync_in_pos [*5];
    endsequence
    sequence first_rise_s;
        arm_r && !run_sel_r && !sync_in_pos && $rose(data_ready_pos[0]);
    endsequence
    sync_pair_a: assert property (sync_in_neg == !sync_in_pos)
        else $error("sync pair not complementary");
    ready_pair_a: assert property (data_ready_neg == ~data_ready_pos)
        else $error("data ready pair not complementary");
    ready_align_a: assert property (data_ready_pos == {sync_pkg::NUM_CH{data_ready_pos[0]}})
        else $error("data ready channels not aligned");
    sync_width_a: assert property ($rose(sync_in_pos) |-> sync_in_pos [*2])
        else $error("sync pulse shorter than minimum");
    clock_freeze_a: assert property (sync_held_s ##0 !run_sel_r |-> $stable(data_ready_pos))
        else $error("data ready moved while frozen");
    clock_run_a: assert property (sync_held_s ##0 run_sel_r |-> data_ready_pos != $past(data_ready_pos))
        else $error("data ready stopped in run mode");
    restart_delay_a: assert property (first_rise_s |-> cnt_r >= {4'h0, ext_r[3:0]} + 8'h02
        && cnt_r <= {4'h0, ext_r[3:0]} + 8'h06)
        else $error("data ready restart delay wrong");
    ext_read_a: assert property (reg_rd && reg_addr == sync_pkg::DEV_EXT_ADDR
        |=> reg_rdata == ext_r)
        else $error("extension readback wrong");
endmodule : adc_sync_restart_assertions

// ### test/adc_sync_restart_control_bench.sv
// Purpose: drives controller software port, checks restart behaviour
// Assumes: both ends joined by one link; device reached via addr bit 4
// Notes: latency compared as differences, absorbing synchroniser offset
`timescale 1ns/1ps
module adc_sync_restart_control_bench;
    logic clk;
    logic rst_n;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic busy;
    logic pipe_run;
    logic decim_tick;
    logic data_valid;
    logic sync_active;
    logic [15:0] v;
    logic [7:0] lat [3];
    logic [7:0] ra [8] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h11, 8'h12, 8'h16, 8'h1F};
    logic [15:0] rv [8] = '{16'h0000, 16'h0004, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] ys [3] = '{16'h0000, 16'h0003, 16'h000F};
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    int i;
    sync_link_if sync_link_if_i ();
    adc_sync_restart_device adc_sync_restart_device_i (.CLK(clk), .RST_N(rst_n),
        .LINK(sync_link_if_i), .PIPE_RUN(pipe_run), .DECIM_TICK(decim_tick),
        .DATA_VALID(data_valid), .SYNC_ACTIVE(sync_active));
    adc_sync_restart_controller adc_sync_restart_controller_i (.CLK(clk), .RST_N(rst_n),
        .LINK(sync_link_if_i), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .BUSY(busy));
    adc_sync_restart_assertions adc_sync_restart_assertions_i (.CLK(clk), .RST_N(rst_n),
        .sync_in_pos(sync_link_if_i.sync_in_pos), .sync_in_neg(sync_link_if_i.sync_in_neg),
        .data_ready_pos(sync_link_if_i.data_ready_pos),
        .data_ready_neg(sync_link_if_i.data_ready_neg), .reg_addr(sync_link_if_i.reg_addr),
        .reg_wdata(sync_link_if_i.reg_wdata), .reg_rdata(sync_link_if_i.reg_rdata),
        .reg_wr(sync_link_if_i.reg_wr), .reg_rd(sync_link_if_i.reg_rd));
    task automatic test_done;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        n_tests++;
        if ((^got) === 1'bx || got < lo || got > hi) begin
            n_fail++;
            $display("unexpected at %0t: %h outside %h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng
    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : bus_rd
    task automatic wait_idle;
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 300) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (busy !== 1'b0) begin
            n_fail++;
            $display("unexpected at %0t: controller stuck busy", $time);
        end
    endtask : wait_idle
    // go, check clock state mid pulse, then fetch measured latency
    task automatic pulse(input logic run_exp, output logic [7:0] l);
        logic [15:0] s;
        bus_wr(8'h00, 16'h0001);
        repeat (5) @(posedge clk);
        #1;
        chk({15'h0000, pipe_run}, {15'h0000, run_exp});
        wait_idle();
        bus_rd(8'h02, s);
        l = s[7:0];
    endtask : pulse
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ceiling well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            $display("unexpected at %0t: timeout", $time);
            test_done();
        end
    end
    initial begin
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i++) begin
            bus_rd(ra[i], v);
            chk(v, rv[i]);
        end
        bus_wr(8'h16, 16'hA5C3);
        bus_rd(8'h16, v);
        chk(v, 16'hA5C3);
        $display("test reset values done");
        bus_wr(8'h01, 16'h0008);
        bus_wr(8'h11, 16'h0000);
        for (i = 0; i < 3; i++) begin
            bus_wr(8'h16, ys[i]);
            pulse(1'b0, lat[i]);
        end
        chk_rng(lat[0], 8'h02, 8'h08);
        chk({8'h00, lat[1] - lat[0]}, 16'h0003);
        chk({8'h00, lat[2] - lat[0]}, 16'h000F);
        $display("test restart extension done");
        bus_wr(8'h11, 16'h0001);
        bus_wr(8'h16, 16'h0000);
        pulse(1'b1, lat[0]);
        bus_wr(8'h01, 16'h0001);
        pulse(1'b1, lat[0]);
        $display("test run select done");
        bus_wr(8'h01, 16'h0008);
        bus_wr(8'h11, 16'h000A);
        i = 0;
        while (decim_tick !== 1'b1 && i < 50) begin
            @(posedge clk);
            #1;
            i++;
        end
        i = 0;
        do begin
            @(posedge clk);
            #1;
            i++;
        end while (decim_tick !== 1'b1 && i < 50);
        chk(16'(i), 16'h0003);
        bus_wr(8'h00, 16'h0001);
        repeat (5) @(posedge clk);
        #1;
        chk({15'h0000, data_valid}, 16'h0000);
        chk({15'h0000, decim_tick}, 16'h0000);
        chk({15'h0000, sync_active}, 16'h0001);
        wait_idle();
        repeat (30) @(posedge clk);
        #1;
        chk({15'h0000, data_valid}, 16'h0001);
        $display("test decimation done");
        // auto mode: a device control write launches a pulse, an extension write does not
        bus_wr(8'h00, 16'h0002);
        bus_wr(8'h16, 16'h0000);
        #1;
        chk({15'h0000, busy}, 16'h0000);
        bus_wr(8'h11, 16'h0008);
        #1;
        chk({15'h0000, busy}, 16'h0001);
        wait_idle();
        bus_rd(8'h02, v);
        chk_rng(v[7:0], 8'h02, 8'h08);
        bus_wr(8'h00, 16'h0000);
        $display("test auto sync done");
        test_done();
    end
endmodule : adc_sync_restart_control_bench
